/* core/ddr2_al_delay.sv */
// additive latency delay line for column commands
`timescale 1ns/100ps
`include "ddr2_cmd_map.svh"
module ddr2_al_delay
  import ddr2_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // programmed latency and command in
  input wire logic [2:0] al,
  input wire col_cmd_s cmd_in,
  // delayed command out, registered
  output col_cmd_s cmd_out
);
  // stage 0 is the command as sampled; stage k is k clocks late
  col_cmd_s stage_r [0:`AL_MAX];
  col_cmd_s pick;
  // tap selection: zero latency still passes through one register
  assign pick = (al > 3'h6) ? stage_r[`AL_MAX] : stage_r[al];
  // shift the pipeline every edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i <= `AL_MAX; i++)
        stage_r[i] <= '0;
      cmd_out <= '0;
    end
    else
    begin
      stage_r[0] <= cmd_in;
      for (int i = 1; i <= `AL_MAX; i++)
        stage_r[i] <= stage_r[i-1];
      cmd_out <= pick;
    end
  end
endmodule

/* core/ddr2_cmd_map.svh */
// timing counts and field positions for the command state logic
`ifndef DDR2_CMD_MAP_SVH
`define DDR2_CMD_MAP_SVH
`define NUM_BANKS 8
`define BANK_W 3
`define ADDR_W 14
`define ROW_W 14
`define COL_W 10
`define AP_BIT 10
`define MASK_W 2
`define AL_W 3
`define AL_MAX 6
`define T_XSRD_CLK 200
`define T_RP_NS 15
`define T_RP_CLK ((`T_RP_NS * 20 + 999) / 1000)
`define T_MRD_CLK 2
`define T_BURST_CLK 4
`define CKE_HOLD_CLK 3
`endif

/* core/ddr2_cmd_pkg.sv */
// types shared by the command state logic
package ddr2_cmd_pkg;
  // decoded command kinds
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_BAD
  } cmd_e;
  // device power state
  typedef enum logic [2:0] {
    ST_NORMAL, ST_ACT_PD, ST_PRE_PD, ST_SELF_REF
  } pwr_e;
  // command pins sampled on one edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [2:0] ba;
    logic [13:0] addr;
  } cmd_pins_s;
  // column access handed to the array side
  typedef struct packed {
    logic valid;
    logic is_write;
    logic auto_pre;
    logic [2:0] bank;
    logic [9:0] col;
  } col_cmd_s;
endpackage

/* core/ddr2_cmd_state.sv */
// command decode, bank and power state tracking for a ddr2 device
`timescale 1ns/100ps
`include "ddr2_cmd_map.svh"
// Overview of operation
// - decode command from pins on rising edge
// - cke edges need nop or deselect, except refresh on a cke fall
// - cke fall enters active/precharge power-down
// - refresh with cke falling enters self refresh
// - dll off in self refresh, on after
// - power-down performs no refresh
// - mask high blocks byte write
// - deselect and nop start nothing new
// - activate opens row until precharge
// - read burst from column, a10 precharges
// - write burst into column, a10 precharges
// - column commands delayed by additive latency
// - precharge closes one or all banks
// - precharge idle bank accepted, restarts timer
// - refresh needs idle banks, internal address
// - odt ignored in self refresh
module ddr2_cmd_state
  import ddr2_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command pins
  input wire cmd_pins_s pins,
  // configuration
  input wire logic [2:0] al,
  input wire logic ocd_cal,
  input wire logic odt_en_cfg,
  // write data beat mask and termination input
  input wire logic wr_beat,
  input wire logic [1:0] dm,
  input wire logic odt,
  // status out
  output pwr_e pwr_r,
  output logic [7:0] bank_open_r,
  output logic dll_on_r,
  output logic odt_on_r,
  output logic [1:0] byte_we_r,
  output logic illegal_r,
  output logic refresh_pulse_r,
  output logic [13:0] ref_row_r,
  output logic mrs_pulse_r,
  output logic [2:0] mrs_sel_r,
  output col_cmd_s col_cmd_r
);
  // previous cke level and hold counter
  logic cke_prev_r;
  logic [1:0] cke_hold_r;
  logic [7:0] xsrd_cnt_r;
  logic [1:0] mrd_cnt_r;
  logic [2:0] burst_cnt_r;
  logic [1:0] rp_cnt_r [0:7];
  cmd_e cmd;
  col_cmd_s col_now;
  // decoded conditions
  wire cke_fall = cke_prev_r & ~pins.cke;
  wire cke_rise = ~cke_prev_r & pins.cke;
  wire cke_chg = cke_fall | cke_rise;
  wire is_idle_cmd = (cmd == CMD_DESEL) || (cmd == CMD_NOP);
  wire all_idle = (bank_open_r == 8'h00);
  wire normal = (pwr_r == ST_NORMAL);
  wire busy = (burst_cnt_r != 3'h0) || (mrd_cnt_r != 2'h0);
  logic pre_busy;
  // any bank still counting precharge time
  always_comb
  begin
    pre_busy = 1'b0;
    for (int b = 0; b < `NUM_BANKS; b++)
      pre_busy = pre_busy | (rp_cnt_r[b] != 2'h0);
  end
  // command decode from the four strobes
  always_comb
  begin
    cmd = CMD_BAD;
    if (pins.cs_n)
      cmd = CMD_DESEL;
    else
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h7: cmd = CMD_NOP;
        3'h0: cmd = CMD_MRS;
        3'h1: cmd = CMD_REF;
        3'h2: cmd = CMD_PRE;
        3'h3: cmd = CMD_ACT;
        3'h4: cmd = CMD_WR;
        3'h5: cmd = CMD_RD;
        default: cmd = CMD_BAD;
      endcase
  end
  // column command presented to the latency line
  assign col_now.valid = normal && pins.cke && cke_prev_r && (cmd == CMD_WR || cmd == CMD_RD);
  assign col_now.is_write = (cmd == CMD_WR);
  assign col_now.auto_pre = pins.addr[`AP_BIT];
  assign col_now.bank = pins.ba;
  assign col_now.col = pins.addr[9:0];
  // column commands registered internally al+1 clocks late
  ddr2_al_delay u_al
  (
    .clk(clk),
    .nrst(nrst),
    .al(al),
    .cmd_in(col_now),
    .cmd_out(col_cmd_r)
  );
  // illegal operation check for the present edge
  logic bad;
  always_comb
  begin
    bad = 1'b0;
    if (cke_chg && !((cke_fall && cmd == CMD_REF) || is_idle_cmd))
      bad = 1'b1;
    if (cke_chg && cke_hold_r != 2'h0)
      bad = 1'b1;
    if (cke_fall && (busy || pre_busy) && normal)
      bad = 1'b1;
    if (cke_fall && cmd == CMD_REF && !all_idle)
      bad = 1'b1;
    if (normal && pins.cke && cke_prev_r)
    begin
      if ((cmd == CMD_MRS || cmd == CMD_REF) && !all_idle)
        bad = 1'b1;
      if (mrd_cnt_r != 2'h0 && !is_idle_cmd)
        bad = 1'b1;
      if ((cmd == CMD_RD || cmd == CMD_WR) && !bank_open_r[pins.ba])
        bad = 1'b1;
      if (cmd == CMD_ACT && (bank_open_r[pins.ba] || rp_cnt_r[pins.ba] != 2'h0))
        bad = 1'b1;
      if (cmd == CMD_RD && xsrd_cnt_r != 8'h00)
        bad = 1'b1;
      if (cmd == CMD_BAD)
        bad = 1'b1;
    end
    if (ocd_cal && !pins.cke)
      bad = 1'b1;
  end
  // power state machine
  pwr_e pwr_nxt;
  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ST_NORMAL:
        if (cke_fall && cmd == CMD_REF)
          pwr_nxt = ST_SELF_REF;
        else if (cke_fall && is_idle_cmd)
          pwr_nxt = all_idle ? ST_PRE_PD : ST_ACT_PD;
      ST_ACT_PD, ST_PRE_PD:
        if (cke_rise)
          pwr_nxt = ST_NORMAL;
      ST_SELF_REF:
        if (cke_rise)
          pwr_nxt = ST_NORMAL;
      default: pwr_nxt = ST_NORMAL;
    endcase
  end
  // bank open map; auto precharge closes at the delayed column command
  logic [7:0] bank_nxt;
  always_comb
  begin
    bank_nxt = bank_open_r;
    if (col_cmd_r.valid && col_cmd_r.auto_pre)
      bank_nxt[col_cmd_r.bank] = 1'b0;
    if (normal && pins.cke && cke_prev_r)
    begin
      if (cmd == CMD_ACT)
        bank_nxt[pins.ba] = 1'b1;
      if (cmd == CMD_PRE)
      begin
        if (pins.addr[`AP_BIT])
          bank_nxt = 8'h00;
        else
          bank_nxt[pins.ba] = 1'b0;
      end
    end
  end
  // state, counters and flags
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_r <= ST_NORMAL;
      bank_open_r <= 8'h00;
      cke_prev_r <= 1'b0;
      cke_hold_r <= 2'h0;
      xsrd_cnt_r <= 8'h00;
      mrd_cnt_r <= 2'h0;
      burst_cnt_r <= 3'h0;
      dll_on_r <= 1'b1;
      illegal_r <= 1'b0;
      refresh_pulse_r <= 1'b0;
      ref_row_r <= 14'h0000;
      mrs_pulse_r <= 1'b0;
      mrs_sel_r <= 3'h0;
      for (int b = 0; b < `NUM_BANKS; b++)
        rp_cnt_r[b] <= 2'h0;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      bank_open_r <= bank_nxt;
      cke_prev_r <= pins.cke;
      // sticky error: once illegal, it holds until the next reset
      illegal_r <= illegal_r | bad;
      // hold window after every cke change
      if (cke_chg)
        cke_hold_r <= 2'(`CKE_HOLD_CLK - 1);
      else if (cke_hold_r != 2'h0)
        cke_hold_r <= cke_hold_r - 2'h1;
      // dll follows self refresh
      if (pwr_nxt == ST_SELF_REF)
        dll_on_r <= 1'b0;
      else
        dll_on_r <= 1'b1;
      // read lockout after self refresh exit
      if (pwr_r == ST_SELF_REF && cke_rise)
        // loaded one short so a read exactly 200 edges after exit is legal
        xsrd_cnt_r <= 8'(`T_XSRD_CLK - 1);
      else if (xsrd_cnt_r != 8'h00)
        xsrd_cnt_r <= xsrd_cnt_r - 8'h01;
      // refresh only from explicit commands, never in power-down
      refresh_pulse_r <= normal && pins.cke && cke_prev_r && cmd == CMD_REF;
      if (normal && pins.cke && cke_prev_r && cmd == CMD_REF)
        ref_row_r <= ref_row_r + 14'h0001;
      // mode register set and its quiet time
      mrs_pulse_r <= normal && pins.cke && cke_prev_r && cmd == CMD_MRS;
      if (normal && pins.cke && cke_prev_r && cmd == CMD_MRS)
      begin
        mrs_sel_r <= pins.ba;
        mrd_cnt_r <= 2'(`T_MRD_CLK - 1);
      end
      else if (mrd_cnt_r != 2'h0)
        mrd_cnt_r <= mrd_cnt_r - 2'h1;
      // burst in progress
      if (col_now.valid)
        burst_cnt_r <= 3'(`T_BURST_CLK);
      else if (burst_cnt_r != 3'h0)
        burst_cnt_r <= burst_cnt_r - 3'h1;
      // precharge timer restarts at the latest precharge
      for (int b = 0; b < `NUM_BANKS; b++)
        if (normal && pins.cke && cke_prev_r && cmd == CMD_PRE &&
            (pins.addr[`AP_BIT] || pins.ba == 3'(b)))
          rp_cnt_r[b] <= 2'(`T_RP_CLK);
        else if (rp_cnt_r[b] != 2'h0)
          rp_cnt_r[b] <= rp_cnt_r[b] - 2'h1;
    end
  end
  // termination gating and write byte enables
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      odt_on_r <= 1'b0;
      byte_we_r <= 2'h0;
    end
    else
    begin
      // termination has no effect in self refresh
      odt_on_r <= odt_en_cfg && odt && (pwr_nxt != ST_SELF_REF);
      // mask low writes the byte, high leaves it
      byte_we_r <= wr_beat ? ~dm : 2'h0;
    end
  end
  // refresh postponement is the controller's job; nothing tracked here
  // self refresh entered with an open bank is flagged illegal
  idle_sr_a: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_r == ST_NORMAL && pwr_nxt == ST_SELF_REF && !all_idle) |=> illegal_r)
    else $error("self refresh entered with open bank");
  // cke fall with nop enters the proper power-down
  pd_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (normal && cke_fall && is_idle_cmd) |=>
      (pwr_r == ($past(all_idle) ? ST_PRE_PD : ST_ACT_PD)))
    else $error("wrong power-down state");
  // refresh with cke falling enters self refresh and stops dll
  sr_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (normal && cke_fall && cmd == CMD_REF) |=> (pwr_r == ST_SELF_REF && !dll_on_r))
    else $error("self refresh not entered");
  // dll back on after exit
  dll_back_a: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_r == ST_SELF_REF && cke_rise) |=> dll_on_r)
    else $error("dll not restored");
  // masked low byte never written
  mask_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_beat && dm[0]) |=> !byte_we_r[0])
    else $error("masked byte written");
  // nop starts no refresh or mode set
  nop_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    is_idle_cmd |=> (!refresh_pulse_r && !mrs_pulse_r))
    else $error("command executed on nop");
  // activate opens the bank
  act_open_a: assert property (@(posedge clk) disable iff (!nrst)
    (normal && pins.cke && cke_prev_r && cmd == CMD_ACT) |=> bank_open_r[$past(pins.ba)])
    else $error("activate did not open bank");
  // precharge all closes everything
  pre_all_a: assert property (@(posedge clk) disable iff (!nrst)
    (normal && pins.cke && cke_prev_r && cmd == CMD_PRE && pins.addr[`AP_BIT]) |=>
      (bank_open_r == 8'h00))
    else $error("precharge all left bank open");
  // termination off in self refresh
  odt_sr_a: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_r == ST_SELF_REF) |-> !odt_on_r)
    else $error("termination active in self refresh");
endmodule

/* tb/ddr2_cmd_state_tb.sv */
// self-checking bench for the ddr2 command state logic
`timescale 1ns/100ps
module ddr2_cmd_state_tb
  import ddr2_cmd_pkg::*;
;
  // clock, reset and device inputs
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cmd_pins_s pins;
  logic [2:0] al = 3'h0;
  logic ocd_cal = 1'b0;
  logic odt_en_cfg = 1'b1;
  logic wr_beat = 1'b0;
  logic [1:0] dm = 2'h0;
  logic odt = 1'b0;
  // device outputs
  pwr_e pwr_r;
  logic [7:0] bank_open_r;
  logic dll_on_r, odt_on_r, illegal_r, refresh_pulse_r, mrs_pulse_r;
  logic [1:0] byte_we_r;
  logic [13:0] ref_row_r;
  logic [2:0] mrs_sel_r;
  col_cmd_s col_cmd_r;
  // run bookkeeping
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  // 20 mhz clock
  always #25 clk = ~clk;

  ddr2_ctrl_model ddr2_ctrl_model_inst (.clk(clk), .pins(pins));

  ddr2_cmd_state ddr2_cmd_state_inst (.clk(clk), .nrst(nrst), .pins(pins), .al(al),
    .ocd_cal(ocd_cal), .odt_en_cfg(odt_en_cfg), .wr_beat(wr_beat), .dm(dm), .odt(odt),
    .pwr_r(pwr_r), .bank_open_r(bank_open_r), .dll_on_r(dll_on_r), .odt_on_r(odt_on_r),
    .byte_we_r(byte_we_r), .illegal_r(illegal_r), .refresh_pulse_r(refresh_pulse_r),
    .ref_row_r(ref_row_r), .mrs_pulse_r(mrs_pulse_r), .mrs_sel_r(mrs_sel_r),
    .col_cmd_r(col_cmd_r));

  // compare one value, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done;
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // command with cke held high; results of it are seen after the next call
  task automatic issue(input logic [3:0] code, input logic [2:0] ba, input logic [13:0] addr);
    ddr2_ctrl_model_inst.cmd(code, 1'b1, ba, addr);
  endtask

  // nops with cke high
  task automatic nops(input int k);
    ddr2_ctrl_model_inst.nop(k, 1'b1);
  endtask

  // column access to bank 1 under a given latency; finds the cycle it emerges
  task automatic col_test(input logic [2:0] lat, input logic [3:0] code, input logic ap);
    int hit;
    col_cmd_s seen;
    hit = -1;
    seen = '0;
    al = lat;
    issue(code, 3'h1, {3'h5, ap, 10'h2a5});
    for (int i = 0; i < 8; i++)
    begin
      nops(1);
      if (col_cmd_r.valid === 1'b1 && hit < 0)
      begin
        hit = i;
        seen = col_cmd_r;
      end
    end
    // the latency line adds one register stage on top of the programmed latency
    chk(hit, {29'h0, lat} + 32'h1);
    chk(seen, {1'b1, code == 4'h4, ap, 3'h1, 10'h2a5});
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #5;
    nrst = 1'b1;
    chk(pwr_r, ST_NORMAL);
    chk(dll_on_r, 1'b1);
    chk(bank_open_r, 8'h00);
    // power-up: cke rises under nop and stays three edges; calibration only once cke is high
    nops(1);
    ocd_cal = 1'b1;
    nops(2);
    ocd_cal = 1'b0;
    // mode set to register two, then the tmrd gap
    issue(4'h0, 3'h2, 14'h0);
    nops(1);
    chk(mrs_pulse_r, 1'b1);
    chk(mrs_sel_r, 3'h2);
    nops(1);
    chk(mrs_pulse_r, 1'b0);
    // two refreshes; address lines carry junk that must be ignored
    for (int i = 1; i <= 2; i++)
    begin
      issue(4'h1, 3'h7, 14'h3fff);
      nops(1);
      chk(refresh_pulse_r, 1'b1);
      chk(ref_row_r, 14'(i));
      nops(2);
    end
    // precharge power-down with all banks idle; termination still follows its pin
    odt = 1'b1;
    ddr2_ctrl_model_inst.nop(3, 1'b0);
    chk(pwr_r, ST_PRE_PD);
    chk(odt_on_r, 1'b1);
    nops(3);
    chk(pwr_r, ST_NORMAL);
    // open bank 1, deselect must change nothing, then active power-down
    issue(4'h3, 3'h1, 14'h1234);
    issue(4'hf, 3'h1, 14'h0);
    nops(1);
    chk(bank_open_r, 8'h02);
    ddr2_ctrl_model_inst.nop(3, 1'b0);
    chk(pwr_r, ST_ACT_PD);
    nops(3);
    chk(pwr_r, ST_NORMAL);
    // every additive latency, reads and writes alternating
    for (int l = 0; l <= 6; l++)
      col_test(3'(l), l[0] ? 4'h4 : 4'h5, 1'b0);
    chk(bank_open_r, 8'h02);
    col_test(3'h3, 4'h5, 1'b1);
    chk(bank_open_r, 8'h00);
    issue(4'h3, 3'h1, 14'h0042);
    nops(1);
    col_test(3'h2, 4'h4, 1'b1);
    chk(bank_open_r, 8'h00);
    // data mask on write beats, every pattern
    al = 3'h0;
    for (int m = 0; m < 4; m++)
    begin
      wr_beat = 1'b1;
      dm = 2'(m);
      nops(1);
      chk(byte_we_r, 32'h3 - 32'(m));
    end
    wr_beat = 1'b0;
    nops(1);
    chk(byte_we_r, 32'h0);
    // single-bank close, repeat close on idle bank, close all
    issue(4'h3, 3'h3, 14'h0);
    issue(4'h3, 3'h5, 14'h0);
    issue(4'h2, 3'h3, 14'h0);
    nops(1);
    chk(bank_open_r, 8'h20);
    issue(4'h2, 3'h3, 14'h0);
    issue(4'h2, 3'h0, 14'h0400);
    nops(2);
    chk(bank_open_r, 8'h00);
    chk(illegal_r, 1'b0);
    // self refresh: refresh with cke falling, termination pin ignored inside
    ddr2_ctrl_model_inst.cmd(4'h1, 1'b0, 3'h0, 14'h0);
    ddr2_ctrl_model_inst.nop(4, 1'b0);
    chk(pwr_r, ST_SELF_REF);
    chk(dll_on_r, 1'b0);
    chk(odt_on_r, 1'b0);
    nops(200);
    chk(pwr_r, ST_NORMAL);
    chk(dll_on_r, 1'b1);
    chk(illegal_r, 1'b0);
    chk(odt_on_r, 1'b1);
    // termination disabled in the mode register stays off with the pin high
    odt_en_cfg = 1'b0;
    nops(1);
    chk(odt_on_r, 1'b0);
    // activate on a falling cke edge is flagged
    ddr2_ctrl_model_inst.cmd(4'h3, 1'b0, 3'h2, 14'h0);
    ddr2_ctrl_model_inst.nop(3, 1'b0);
    chk(illegal_r, 1'b1);
    // second reset in mid-run clears the sticky error; cke stays low throughout
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    nrst = 1'b1;
    chk(illegal_r, 1'b0);
    // calibration while cke is low is flagged
    ocd_cal = 1'b1;
    ddr2_ctrl_model_inst.nop(1, 1'b0);
    chk(illegal_r, 1'b1);
    test_done();
  end

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
endmodule

/* tb/ddr2_ctrl_model.sv */
// controller-side model that drives the device command pins
`timescale 1ns/100ps
module ddr2_ctrl_model
  import ddr2_cmd_pkg::*;
(
  // clock
  input wire logic clk,
  // command pins toward the device
  output cmd_pins_s pins
);
  // cke starts low, so the first high edge is a clean rise under nop
  initial pins = {4'hf, 1'b0, 3'h0, 14'h0};

  // one command per edge, changed just after the rising edge and held a full cycle
  task automatic cmd(input logic [3:0] code, input logic cke, input logic [2:0] ba,
                     input logic [13:0] addr);
    @(posedge clk);
    #5;
    pins = {code, cke, ba, addr};
  endtask

  // nop edges at a fixed cke level; unused address lines flip every edge so a
  // stale value can never pass for a real one
  task automatic nop(input int n, input logic cke);
    repeat (n) cmd(4'h7, cke, ~pins.ba, ~pins.addr);
  endtask
endmodule
